// [hdl/spo_chan_ratio_code_decode.sv]
// Channel divider code decode into overall ratio and six segment ratios.
// Purely combinational; the caller registers the results.
`timescale 1ns/10ps
`default_nettype none
module spo_ratio_decode (
  input  wire logic [spo_pkg::SPO_CODE_W-1:0]              code,
  output logic      [spo_pkg::SPO_RATIO_W-1:0]             ratio,
  output logic      [spo_pkg::SPO_SEG_N*spo_pkg::SPO_SEG_W-1:0] segs,
  output logic                                             valid
);
  import spo_pkg::*;

  always_comb begin
    logic [3:0]           pow;
    logic [3:0]           rem;
    logic [3:0]           step;
    logic [SPO_SEG_W-1:0] seg0;
    pow   = '0;
    rem   = '0;
    step  = '0;
    seg0  = SPO_SEG_TWO;
    valid = (code >= SPO_CODE_ONE) && (code <= SPO_CODE_MAX);
    if (code == SPO_CODE_ONE) begin
      pow = '0;
    end else if (code < SPO_CODE_PAIR_BASE) begin
      pow  = SPO_POW_LOW;
      seg0 = (code == SPO_CODE_THREE) ? SPO_SEG_THREE : SPO_SEG_TWO;
    end else begin
      pow  = 4'((code - SPO_CODE_PAIR_BASE) >> 1) + SPO_POW_PAIR;
      seg0 = code[0] ? SPO_SEG_THREE : SPO_SEG_TWO;
    end
    ratio = valid ? (SPO_RATIO_W'(seg0) << pow) : '0;
    // Product of six stages: first gives 2 or 3 (1 for an invalid code), the rest give 1, 2 or 4
    segs[SPO_SEG_W-1:0] = valid ? seg0 : SPO_SEG_ONE;
    rem = valid ? pow : '0;
    for (int i = 1; i < SPO_SEG_N; i++) begin
      step = (rem > 4'(SPO_SEG_STEP_MAX)) ? 4'(SPO_SEG_STEP_MAX) : rem;
      segs[i*SPO_SEG_W +: SPO_SEG_W] = SPO_SEG_ONE << step;
      rem = rem - step;
    end
  end
endmodule
`default_nettype wire

// [hdl/spo_output_ctrl.sv]
// Output-path controller: divider decode and gating, muting, routing, power levels,
// sleep and calibration triggers, strap-mode pin decode.
// Assumes strap pins arrive as 2-bit level codes from pin comparators, asynchronous to clk.
// Contract
// - Channel divider is six cascaded stages; ratio is their product.
// - Code 1..19 decodes to 2,4,6,8,12,...,1536.
// - Code 3 gives six; strap code 0 means serial configuration.
// - Divider powered if either output selects divider or sysref, even if disabled; sysref counts in serial mode only, and power-down turns it off.
// - Mute follows its pin, active level chosen by polarity bit in serial mode.
// - Muting never stops lock or programming.
// - Outputs A and B have independent mute controls.
// - Mute pins work in both modes; serial bit picks register or pin.
// - Doubled VCO may be routed to either output by the select.
// - Eight select codes map sources for outputs A and B.
// - Each VCO calibration also starts the doubler filter calibration.
// - Buffer power has eight levels and resets to seven.
// - A buffer may be disabled while the loop stays locked.
// - Sleep bit set or run pin low enters power-down.
// - Clearing the bit, or run pin high when it caused it, resumes.
// - Divider pins not all low select strap mode and lock out serial.
// - Strap mode uses integer feedback ratio from pins only.
// - Six feedback pins give 4096 codes; three divider pins give 64.
// - Each pin resolves to one of four levels.
// - Levels weigh 0..3; first feedback pin is most significant digit.
`timescale 1ns/10ps
`default_nettype none
module spo_output_ctrl (
  input  wire logic                                         clk,
  input  wire logic                                         rst_n,
  input  wire logic [spo_pkg::SPO_ADDR_W-1:0]               addr,
  input  wire logic [spo_pkg::SPO_DATA_W-1:0]               wdata,
  input  wire logic                                         wr_en,
  input  wire logic                                         rd_en,
  output logic      [spo_pkg::SPO_DATA_W-1:0]               rdata,
  input  wire logic [spo_pkg::SPO_STRAP_FB_W-1:0]           feedback_ratio_pins,
  input  wire logic [spo_pkg::SPO_CH_PIN_W-1:0]             chan_ratio_pins,
  input  wire logic [spo_pkg::SPO_SEL_W-1:0]                output_source_select_pins,
  input  wire logic                                         run_cal_pin,
  input  wire logic                                         silence_a_pin,
  input  wire logic                                         silence_b_pin,
  output spo_pkg::spo_src_type                              output_a_src,
  output spo_pkg::spo_src_type                              output_b_src,
  output logic                                              output_a_mute,
  output logic                                              output_b_mute,
  output logic                                              output_a_enable,
  output logic                                              output_b_enable,
  output logic      [spo_pkg::SPO_PWR_W-1:0]                out_power_a,
  output logic      [spo_pkg::SPO_PWR_W-1:0]                out_power_b,
  output logic      [spo_pkg::SPO_RATIO_W-1:0]              chan_ratio,
  output logic      [spo_pkg::SPO_SEG_N*spo_pkg::SPO_SEG_W-1:0] chan_ratio_segments,
  output logic                                              chan_div_power,
  output logic      [spo_pkg::SPO_FB_W-1:0]                 feedback_ratio,
  output logic                                              sleep_active,
  output logic                                              vco_cal_start,
  output logic                                              filter_cal_start,
  output logic                                              strap_mode
);
  import spo_pkg::*;

  typedef struct packed {
    logic [SPO_DATA_W-1:0]           rdata;
    logic                            sleep_req;
    logic [SPO_CODE_W-1:0]           ratio_code;
    logic [SPO_SEL_W-1:0]            sel;
    logic [SPO_PWR_W-1:0]            pwr_a;
    logic [SPO_PWR_W-1:0]            pwr_b;
    logic                            pol;
    logic                            byreg;
    logic                            sil_a;
    logic                            sil_b;
    logic                            en_a;
    logic                            en_b;
    logic                            sys_a;
    logic                            sys_b;
    logic [SPO_FB_W-1:0]             fb_ser;
    logic                            cal_prev;
    logic [SPO_STRAP_FB_W-1:0]       strap_fb;
    logic [SPO_CODE_W-1:0]           strap_code;
    logic [SPO_SEL_W-1:0]            strap_sel;
    logic                            strap;
    spo_src_type                     src_a;
    spo_src_type                     src_b;
    logic                            mute_a;
    logic                            mute_b;
    logic                            div_pwr;
    logic [SPO_RATIO_W-1:0]          ratio;
    logic [SPO_SEG_N*SPO_SEG_W-1:0]  segs;
    logic [SPO_FB_W-1:0]             fb_out;
    logic                            sleeping;
    logic                            sleep_by_pin;
    logic                            vco_cal;
    logic                            filt_cal;
  } spo_state_type;

  localparam spo_state_type ST_RESET = '{
    ratio_code: SPO_CODE_RESET,
    sel:     SPO_SEL_RESET,
    pwr_a:   SPO_PWR_RESET,
    pwr_b:   SPO_PWR_RESET,
    en_a:    1'b1,
    en_b:    1'b1,
    fb_ser:  SPO_FB_RESET,
    src_a:   SPO_SRC_VCO,
    src_b:   SPO_SRC_VCO,
    default: '0
  };

  spo_state_type st_q;
  spo_state_type st_d;

  logic [SPO_SYNC_W-1:0]          sync_q;
  logic                           cal_s;
  logic                           sil_b_s;
  logic                           sil_a_s;
  logic [SPO_SEL_W-1:0]           sel_s;
  logic [SPO_CH_PIN_W-1:0]        ch_s;
  logic [SPO_STRAP_FB_W-1:0]      fb_s;
  logic [SPO_CODE_W-1:0]          eff_code;
  logic [SPO_RATIO_W-1:0]         dec_ratio;
  logic [SPO_SEG_N*SPO_SEG_W-1:0] dec_segs;

  // Strap pins change at board speed only, so per-bit synchronising is enough
  spo_sync #(
    .W (SPO_SYNC_W)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({run_cal_pin, silence_b_pin, silence_a_pin, output_source_select_pins,
             chan_ratio_pins, feedback_ratio_pins}),
    .q     (sync_q)
  );

  assign {cal_s, sil_b_s, sil_a_s, sel_s, ch_s, fb_s} = sync_q;

  // Strap divider pins: upper pair gives a step index, lowest pin picks x1 or x1.5
  function automatic logic [SPO_CODE_W-1:0] strap_code_of(
    input logic [SPO_CH_PIN_W-1:0] pins
  );
    logic [3:0] k;
    logic       lo;
    logic       hi;
    k  = pins[SPO_CH_PIN_W-1:SPO_LVL_W];
    lo = (pins[SPO_LVL_W-1:0] == SPO_LVL_LOW);
    hi = (pins[SPO_LVL_W-1:0] == SPO_LVL_HIGH);
    if (k == SPO_STRAP_K_ONE && lo) begin
      return SPO_CODE_ONE;
    end else if (k >= SPO_STRAP_K_MIN && k <= SPO_STRAP_K_MAX && (lo || hi) &&
                 k != SPO_STRAP_K_MIN + SPO_STRAP_K_ONE) begin
      // Index three is unused, so every index above it sits one code pair lower
      return SPO_CODE_W'({k, hi}) - SPO_STRAP_OFFSET -
             ((k > SPO_STRAP_K_MIN) ? SPO_STRAP_OFFSET : '0);
    end else begin
      return '0;
    end
  endfunction

  assign eff_code = st_q.strap ? st_q.strap_code : st_q.ratio_code;

  spo_ratio_decode u_ratio_decode (
    .code  (eff_code),
    .ratio (dec_ratio),
    .segs  (dec_segs),
    .valid ()
  );

  always_comb begin
    logic             cal_rise;
    logic             tune_wr;
    logic             sleep_now;
    logic             need_div;
    logic [SPO_SEL_W-1:0] eff_sel;
    spo_src_type      src_a;
    spo_src_type      src_b;
    cal_rise  = cal_s && !st_q.cal_prev;
    tune_wr   = 1'b0;
    sleep_now = 1'b0;
    need_div  = 1'b0;
    eff_sel   = '0;
    src_a     = SPO_SRC_VCO;
    src_b     = SPO_SRC_VCO;
    st_d      = st_q;
    st_d.rdata    = '0;
    st_d.cal_prev = cal_s;
    st_d.strap    = (ch_s != '0);

    // Pins are held between run pin rises so a half-changed set is never used
    if (cal_rise) begin
      st_d.strap_fb    = fb_s;
      st_d.strap_code  = strap_code_of(ch_s);
      st_d.strap_sel   = sel_s;
    end

    // Serial writes land whatever the mute state, so a muted output can retune
    if (wr_en && !st_q.strap) begin
      unique case (addr)
        SPO_REG_CTRL0: begin
          st_d.sleep_req = wdata[SPO_C0_SLEEP_BIT];
          tune_wr        = wdata[SPO_C0_TUNE_BIT];
        end
        SPO_REG_OUTCFG: begin
          st_d.ratio_code = wdata[SPO_OC_CODE_LSB +: SPO_CODE_W];
          st_d.sel   = wdata[SPO_OC_SEL_LSB +: SPO_SEL_W];
          st_d.pwr_a = wdata[SPO_OC_PWRA_LSB +: SPO_PWR_W];
          st_d.pwr_b = wdata[SPO_OC_PWRB_LSB +: SPO_PWR_W];
          st_d.pol   = wdata[SPO_OC_POL_BIT];
          st_d.byreg = wdata[SPO_OC_BYREG_BIT];
          st_d.sil_a = wdata[SPO_OC_SILA_BIT];
          st_d.sil_b = wdata[SPO_OC_SILB_BIT];
          st_d.en_a  = wdata[SPO_OC_ENA_BIT];
          st_d.en_b  = wdata[SPO_OC_ENB_BIT];
          st_d.sys_a = wdata[SPO_OC_SYSA_BIT];
          st_d.sys_b = wdata[SPO_OC_SYSB_BIT];
        end
        SPO_REG_FBDIV: begin
          st_d.fb_ser = wdata[SPO_FB_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Power-down: bit or run pin low; pin release only resumes if the bit is clear
    sleep_now         = st_d.sleep_req || !cal_s;
    st_d.sleeping     = sleep_now;
    st_d.sleep_by_pin = !cal_s;

    // Doubler filter calibration rides on every VCO calibration
    st_d.vco_cal  = !sleep_now && (tune_wr || (st_q.strap && cal_rise));
    st_d.filt_cal = st_d.vco_cal;

    eff_sel = st_q.strap ? st_q.strap_sel : st_q.sel;
    unique case (eff_sel)
      3'h0: begin src_a = SPO_SRC_DIV; src_b = SPO_SRC_DIV; end
      3'h1: begin src_a = SPO_SRC_DIV; src_b = SPO_SRC_VCO; end
      3'h2: begin src_a = SPO_SRC_VCO; src_b = SPO_SRC_DIV; end
      3'h3: begin src_a = SPO_SRC_VCO; src_b = SPO_SRC_VCO; end
      3'h4: begin src_a = SPO_SRC_DBL; src_b = SPO_SRC_DIV; end
      3'h5: begin src_a = SPO_SRC_VCO; src_b = SPO_SRC_DBL; end
      3'h6: begin src_a = SPO_SRC_DBL; src_b = SPO_SRC_VCO; end
      3'h7: begin src_a = SPO_SRC_DBL; src_b = SPO_SRC_DBL; end
    endcase
    st_d.src_a = src_a;
    st_d.src_b = src_b;

    // Buffer enables play no part here: a disabled output still holds the divider on
    need_div = (src_a == SPO_SRC_DIV) || (src_b == SPO_SRC_DIV) ||
               (!st_q.strap && (st_q.sys_a || st_q.sys_b));
    st_d.div_pwr   = need_div && !sleep_now;
    st_d.ratio     = dec_ratio;
    st_d.segs      = dec_segs;

    // Strap mode has no register path, so the pins rule with the low-active default
    if (!st_q.strap && st_q.byreg) begin
      st_d.mute_a = st_q.sil_a;
      st_d.mute_b = st_q.sil_b;
    end else begin
      st_d.mute_a = !(sil_a_s ^ (st_q.pol && !st_q.strap));
      st_d.mute_b = !(sil_b_s ^ (st_q.pol && !st_q.strap));
    end

    st_d.fb_out = st_q.strap ? SPO_FB_W'(st_q.strap_fb) : st_q.fb_ser;

    if (rd_en) begin
      unique case (addr)
        SPO_REG_CTRL0: begin
          st_d.rdata[SPO_C0_SLEEP_BIT] = st_q.sleep_req;
        end
        SPO_REG_OUTCFG: begin
          st_d.rdata[SPO_OC_CODE_LSB +: SPO_CODE_W]   = st_q.ratio_code;
          st_d.rdata[SPO_OC_SEL_LSB +: SPO_SEL_W]     = st_q.sel;
          st_d.rdata[SPO_OC_PWRA_LSB +: SPO_PWR_W]    = st_q.pwr_a;
          st_d.rdata[SPO_OC_PWRB_LSB +: SPO_PWR_W]    = st_q.pwr_b;
          st_d.rdata[SPO_OC_POL_BIT]                  = st_q.pol;
          st_d.rdata[SPO_OC_BYREG_BIT]                = st_q.byreg;
          st_d.rdata[SPO_OC_SILA_BIT]                 = st_q.sil_a;
          st_d.rdata[SPO_OC_SILB_BIT]                 = st_q.sil_b;
          st_d.rdata[SPO_OC_ENA_BIT]                  = st_q.en_a;
          st_d.rdata[SPO_OC_ENB_BIT]                  = st_q.en_b;
          st_d.rdata[SPO_OC_SYSA_BIT]                 = st_q.sys_a;
          st_d.rdata[SPO_OC_SYSB_BIT]                 = st_q.sys_b;
        end
        SPO_REG_FBDIV: begin
          st_d.rdata[SPO_FB_W-1:0] = st_q.fb_out;
        end
        SPO_REG_STATUS: begin
          st_d.rdata[SPO_ST_STRAP_BIT] = st_q.strap;
          st_d.rdata[SPO_ST_SLEEP_BIT] = st_q.sleeping;
          st_d.rdata[SPO_ST_BYPIN_BIT] = st_q.sleep_by_pin;
          st_d.rdata[SPO_ST_BAD_BIT]   = st_q.strap && (st_q.strap_code == '0);
          st_d.rdata[SPO_ST_PWR_BIT]   = st_q.div_pwr;
          st_d.rdata[SPO_ST_RATIO_LSB +: SPO_RATIO_W] = st_q.ratio;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata               = st_q.rdata;
  assign output_a_src        = st_q.src_a;
  assign output_b_src        = st_q.src_b;
  assign output_a_mute       = st_q.mute_a;
  assign output_b_mute       = st_q.mute_b;
  assign output_a_enable     = st_q.en_a;
  assign output_b_enable     = st_q.en_b;
  assign out_power_a         = st_q.pwr_a;
  assign out_power_b         = st_q.pwr_b;
  assign chan_ratio          = st_q.ratio;
  assign chan_ratio_segments = st_q.segs;
  assign chan_div_power      = st_q.div_pwr;
  assign feedback_ratio      = st_q.fb_out;
  assign sleep_active        = st_q.sleeping;
  assign vco_cal_start       = st_q.vco_cal;
  assign filter_cal_start    = st_q.filt_cal;
  assign strap_mode          = st_q.strap;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  div_power_a: assert property (
    (!st_q.sleeping && (st_q.src_a == SPO_SRC_DIV || st_q.src_b == SPO_SRC_DIV))
    |-> st_q.div_pwr)
    else $error("divider unpowered while an output selects it");

  ratio_top_a: assert property (
    (eff_code == SPO_CODE_MAX) |=> (st_q.ratio == SPO_RATIO_MAX))
    else $error("top divider code did not give the largest ratio");

  strap_lock_a: assert property (
    (st_q.strap && wr_en) |=> ($stable(st_q.fb_ser) && $stable(st_q.sel)))
    else $error("serial write took effect in strap mode");

  mute_pin_a: assert property (
    (!st_q.strap && !st_q.byreg) |=> (st_q.mute_a == !($past(sil_a_s) ^ $past(st_q.pol))))
    else $error("mute A does not follow its pin and polarity");

  cal_pair_a: assert property (
    (wr_en && addr == SPO_REG_CTRL0 && wdata[SPO_C0_TUNE_BIT] && !wdata[SPO_C0_SLEEP_BIT]
     && !st_q.strap && cal_s) |=> (st_q.vco_cal && st_q.filt_cal)
     ##1 (!st_q.vco_cal || $past(wr_en && addr == SPO_REG_CTRL0)))
    else $error("tune start did not pulse both calibrations");

  power_hold_a: assert property (
    !(wr_en && addr == SPO_REG_OUTCFG) |=> $stable(st_q.pwr_a))
    else $error("buffer power changed without a write");

  sleep_enter_a: assert property (
    !cal_s |=> (st_q.sleeping && st_q.sleep_by_pin && !st_q.div_pwr))
    else $error("low run pin did not enter power-down");

  sleep_leave_a: assert property (
    (cal_s && !st_q.sleep_req && !wr_en) |=> !st_q.sleeping)
    else $error("power-down not released");

  strap_sample_a: assert property (
    (cal_s && !st_q.cal_prev) |=> (st_q.strap_fb == $past(fb_s)))
    else $error("strap feedback pins not captured on run pin rise");

  strap_hold_a: assert property (
    !(cal_s && !st_q.cal_prev) |=> $stable(st_q.strap_fb))
    else $error("strap feedback value moved between run pin rises");
endmodule
`default_nettype wire

// [hdl/spo_pkg.sv]
// Shared constants, types and register map of the synthesizer output-path controller.
// Assumes a single 100 MHz clock domain and a plain address/strobe register port.
package spo_pkg;

  localparam int SPO_ADDR_W    = 8;
  localparam int SPO_DATA_W    = 32;
  localparam int SPO_CODE_W    = 5;
  localparam int SPO_RATIO_W   = 11;
  localparam int SPO_SEG_N     = 6;
  localparam int SPO_SEG_W     = 3;
  localparam int SPO_PWR_W     = 3;
  localparam int SPO_SEL_W     = 3;
  localparam int SPO_LVL_W     = 2;
  localparam int SPO_FB_PIN_N  = 6;
  localparam int SPO_CH_PIN_N  = 3;
  localparam int SPO_FB_W      = 16;
  localparam int SPO_STRAP_FB_W = SPO_FB_PIN_N * SPO_LVL_W;
  localparam int SPO_CH_PIN_W  = SPO_CH_PIN_N * SPO_LVL_W;
  localparam int SPO_SYNC_W    = SPO_STRAP_FB_W + SPO_CH_PIN_W + SPO_SEL_W + 3;
  localparam int SPO_SEG_STEP_MAX = 2;

  // Register word addresses
  localparam logic [SPO_ADDR_W-1:0] SPO_REG_CTRL0  = 8'h00;
  localparam logic [SPO_ADDR_W-1:0] SPO_REG_OUTCFG = 8'h04;
  localparam logic [SPO_ADDR_W-1:0] SPO_REG_FBDIV  = 8'h08;
  localparam logic [SPO_ADDR_W-1:0] SPO_REG_STATUS = 8'h0c;

  // control_reg_zero fields
  localparam int SPO_C0_TUNE_BIT  = 0;
  localparam int SPO_C0_SLEEP_BIT = 1;

  // Output configuration fields
  localparam int SPO_OC_CODE_LSB  = 0;
  localparam int SPO_OC_SEL_LSB   = 5;
  localparam int SPO_OC_PWRA_LSB  = 8;
  localparam int SPO_OC_PWRB_LSB  = 11;
  localparam int SPO_OC_POL_BIT   = 14;
  localparam int SPO_OC_BYREG_BIT = 15;
  localparam int SPO_OC_SILA_BIT  = 16;
  localparam int SPO_OC_SILB_BIT  = 17;
  localparam int SPO_OC_ENA_BIT   = 18;
  localparam int SPO_OC_ENB_BIT   = 19;
  localparam int SPO_OC_SYSA_BIT  = 20;
  localparam int SPO_OC_SYSB_BIT  = 21;

  // Status fields
  localparam int SPO_ST_STRAP_BIT = 0;
  localparam int SPO_ST_SLEEP_BIT = 1;
  localparam int SPO_ST_BYPIN_BIT = 2;
  localparam int SPO_ST_BAD_BIT   = 3;
  localparam int SPO_ST_PWR_BIT   = 4;
  localparam int SPO_ST_RATIO_LSB = 16;

  // Reset values
  localparam logic [SPO_PWR_W-1:0]   SPO_PWR_RESET   = 3'h7;
  localparam logic [SPO_CODE_W-1:0]  SPO_CODE_RESET  = 5'h01;
  localparam logic [SPO_SEL_W-1:0]   SPO_SEL_RESET   = 3'h3;
  localparam logic [SPO_FB_W-1:0]    SPO_FB_RESET    = 16'h0064;

  // Divider code landmarks
  localparam logic [SPO_CODE_W-1:0]  SPO_CODE_ONE        = 5'h01;
  localparam logic [SPO_CODE_W-1:0]  SPO_CODE_THREE      = 5'h03;
  localparam logic [SPO_CODE_W-1:0]  SPO_CODE_PAIR_BASE  = 5'h04;
  localparam logic [SPO_CODE_W-1:0]  SPO_CODE_MAX        = 5'h13;
  localparam logic [SPO_RATIO_W-1:0] SPO_RATIO_MAX       = 11'h600;
  localparam logic [3:0]             SPO_POW_LOW         = 4'h1;
  localparam logic [3:0]             SPO_POW_PAIR        = 4'h2;
  localparam logic [SPO_SEG_W-1:0]   SPO_SEG_ONE         = 3'h1;
  localparam logic [SPO_SEG_W-1:0]   SPO_SEG_TWO         = 3'h2;
  localparam logic [SPO_SEG_W-1:0]   SPO_SEG_THREE       = 3'h3;

  // Strap pin pair index (upper two pins) landmarks
  localparam logic [3:0]             SPO_STRAP_K_ONE  = 4'h1;
  localparam logic [3:0]             SPO_STRAP_K_MIN  = 4'h2;
  localparam logic [3:0]             SPO_STRAP_K_MAX  = 4'hb;
  localparam logic [SPO_CODE_W-1:0]  SPO_STRAP_OFFSET = 5'h02;

  typedef enum logic [1:0] {SPO_SRC_DIV, SPO_SRC_VCO, SPO_SRC_DBL} spo_src_type;
  typedef enum logic [1:0] {SPO_LVL_LOW, SPO_LVL_MID_LOW, SPO_LVL_MID_HIGH, SPO_LVL_HIGH}
    spo_level_type;

endpackage

// [hdl/spo_sync.sv]
// Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes each bit is an independent slow level; no word coherence is promised.
`timescale 1ns/10ps
`default_nettype none
module spo_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } spo_sync_state_type;

  spo_sync_state_type st_q;
  spo_sync_state_type st_d;

  always_comb begin
    st_d.first  = d;
    st_d.second = st_q.first;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.second;
endmodule
`default_nettype wire

// [sim/spo_board_model.sv]
// Board model: strap pins and run/calibration pin facing the output-path controller.
// Assumes the bench asks for pin levels through want; the model sequences them.
`timescale 1ns/10ps
`default_nettype none
module spo_board_model (
  input  wire logic        clk,
  input  wire logic        hold_low,
  input  wire logic [20:0] want,
  output logic      [20:0] pins,
  output logic             run_pin
);
  logic [3:0] cnt;
  initial begin
    pins = '0;
    cnt = '0;
    run_pin = 1'b1;
  end
  // Pins settle first, then run pin is toggled low and back high
  always @(posedge clk) begin
    if (want !== pins) begin
      pins <= want;
      cnt <= 4'h8;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
    run_pin <= !hold_low && !(cnt != 4'h0 && cnt <= 4'h4);
  end
endmodule
`default_nettype wire

// [sim/synth_output_path_ctrl_tb.sv]
// Self-checking bench for the output-path controller: register writes and pin sequences.
// Assumes a 100 MHz clock and the board model for strap and run pins.
`timescale 1ns/10ps
`default_nettype none
module synth_output_path_ctrl_tb;
  import spo_pkg::*;
  localparam logic [31:0] BASE = 32'h000c3f61;
  logic clk, rst_n, wr_en, rd_en, run_cal_pin, silence_a_pin, silence_b_pin, hold;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [20:0] want;
  logic [11:0] feedback_ratio_pins;
  logic [5:0] chan_ratio_pins;
  logic [2:0] output_source_select_pins, out_power_a, out_power_b;
  spo_src_type output_a_src, output_b_src;
  logic output_a_mute, output_b_mute, output_a_enable, output_b_enable, chan_div_power;
  logic sleep_active, vco_cal_start, filter_cal_start, strap_mode;
  logic [10:0] chan_ratio;
  logic [17:0] chan_ratio_segments;
  logic [15:0] feedback_ratio;
  int n_errors, checks, r, p;
  spo_board_model brd (.clk, .hold_low(hold), .want, .run_pin(run_cal_pin),
    .pins({feedback_ratio_pins, chan_ratio_pins, output_source_select_pins}));
  spo_output_ctrl DUT (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .feedback_ratio_pins, .chan_ratio_pins, .output_source_select_pins, .run_cal_pin,
    .silence_a_pin, .silence_b_pin, .output_a_src, .output_b_src, .output_a_mute,
    .output_b_mute, .output_a_enable, .output_b_enable, .out_power_a, .out_power_b,
    .chan_ratio, .chan_ratio_segments, .chan_div_power, .feedback_ratio, .sleep_active,
    .vco_cal_start, .filter_cal_start, .strap_mode);
  function automatic logic [10:0] ratio_of(int c);
    if (c < 4) return 11'(2 * c);
    return 11'((c[0] ? 12 : 8) << ((c - 4) / 2));
  endfunction
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test;
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, wr_en, rd_en, silence_a_pin, silence_b_pin, hold} = '0;
    {addr, wdata, want, n_errors, checks} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    settle(2);
    chk("boot_sleep", sleep_active, 1);
    // Synchronised run pin must clear sleep in bounded time
    for (r = 0; r < 20 && sleep_active !== 1'b0; r++) @(posedge clk);
    if (sleep_active !== 1'b0) begin
      n_errors++;
      stop_test();
    end
    rd(SPO_REG_OUTCFG);
    chk("outcfg", v, BASE);
    chk("pwr_b_en", {out_power_b, output_b_enable}, 4'hf);
    for (int c = 1; c < 20; c++) begin
      wr(SPO_REG_OUTCFG, (BASE & ~32'h1f) | c);
      settle(2);
      chk("ratio", chan_ratio, ratio_of(c));
      p = 1;
      for (int k = 0; k < 6; k++) p *= chan_ratio_segments[k*3+:3];
      chk("segs", p, ratio_of(c));
    end
    for (int s = 0; s < 8; s++) begin
      wr(SPO_REG_OUTCFG, (BASE & ~32'he0) | (s << 5)); // BASE keeps sysref bits clear so divider power follows the select
      settle(2);
      chk("src_a", output_a_src, 16'ha650 >> (2 * s) & 3);
      chk("src_b", output_b_src, 16'h9844 >> (2 * s) & 3);
      chk("divpwr", chan_div_power, 8'h17 >> s & 1);
    end
    wr(SPO_REG_OUTCFG, BASE | 32'h100000);
    settle(2);
    chk("sysref_pwr", chan_div_power, 1);
    wr(SPO_REG_OUTCFG, BASE & ~32'h400e0);
    settle(2);
    chk("en_a", output_a_enable, 0);
    chk("off_pwr", chan_div_power, 1);
    silence_a_pin <= 1'b1;
    wr(SPO_REG_OUTCFG, BASE | 32'h4000);
    settle(4);
    chk("pin_mute", {output_a_mute, output_b_mute}, 2'b10);
    wr(SPO_REG_OUTCFG, BASE | 32'h28000);
    settle(2);
    chk("reg_mute", {output_a_mute, output_b_mute}, 2'b01);
    wr(SPO_REG_CTRL0, 1);
    chk("cal", {vco_cal_start, filter_cal_start}, 2'b11);
    wr(SPO_REG_CTRL0, 3);
    chk("cal_off", {vco_cal_start, filter_cal_start}, 2'b00);
    settle(2);
    chk("sleep", sleep_active, 1);
    wr(SPO_REG_CTRL0, 0);
    settle(2);
    chk("wake", sleep_active, 0);
    wr(SPO_REG_CTRL0, 1); // Recalibrate after resume
    chk("recal", {vco_cal_start, filter_cal_start}, 2'b11);
    hold <= 1'b1;
    settle(6);
    chk("pin_sleep", sleep_active, 1);
    hold <= 1'b0;
    settle(6);
    chk("pin_wake", sleep_active, 0);
    want <= {12'h069, 6'b001011, 3'b110};
    settle(30);
    chk("strap", strap_mode, 1);
    chk("strap_ratio", chan_ratio, 6);
    chk("strap_fb", feedback_ratio, 105);
    chk("strap_src", {output_a_src, output_b_src}, {SPO_SRC_DBL, SPO_SRC_VCO});
    chk("strap_mute", {output_a_mute, output_b_mute}, 2'b01);
    want <= {12'h069, 6'b101111, 3'b110};
    settle(30);
    chk("strap_top", chan_ratio, 1536);
    wr(SPO_REG_OUTCFG, 0);
    settle(2);
    chk("locked_out", out_power_a, 7);
    stop_test();
  end
endmodule
`default_nettype wire
